// ### common/rfm_defines.vh
/*
  constants for the range fault monitor: window limits, counter widths,
  settle times and clamp value.
  assumes 14-bit adc codes for all monitored quantities except the main supply, which takes a 16-bit code.
*/
`ifndef RFM_DEFINES_VH
`define RFM_DEFINES_VH

`define RFM_CODE_W 14
`define RFM_CHK_N 8
`define RFM_LIMIT_LSB 16
`define RFM_LIMIT_MSB 19
`define RFM_RB_W 12
`define RFM_CLAMP_VAL 12'h0FFE
// common mode window as percent of regulated reference
`define RFM_VCM_LO_PCT 30
`define RFM_VCM_HI_PCT 80
// divisor that turns a percent product back into a code
`define RFM_PCT_FULL 7'h64
// core rail window in millivolts
`define RFM_CORE_LO_MV 1600
`define RFM_CORE_HI_MV 2200
// main supply window in millivolts (tolerance about two volts)
`define RFM_MAIN_LO_MV 5300
`define RFM_MAIN_HI_MV 20000
// settle times in milliseconds and clock rate
`define RFM_SETTLE_FAST_MS 25
`define RFM_SETTLE_SLOW_MS 55
`define RFM_CLK_KHZ 25000
`define RFM_TMR_W 21
// check index
`define RFM_CHK_TEMP 0
`define RFM_CHK_VCM 1
`define RFM_CHK_BIAS 2
`define RFM_CHK_D5V 3
`define RFM_CHK_A5V 4
`define RFM_CHK_CORE 5
`define RFM_CHK_MAIN 6
`define RFM_CHK_SPARE 7
`define RFM_CNT_W 4

`endif

// ### src/rfm_fail_counter.v
/*
  one consecutive-failure counter per check.
  assumes sample_vld_i pulses once per new sample of that check.
*/
`include "rfm_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module rfm_fail_counter (
  // clock and reset
  input wire mclk_i,
  input wire sys_rst_i,
  // sample result
  input wire sample_vld_i,
  input wire sample_bad_i,
  input wire [`RFM_CNT_W-1:0] limit_i,
  // fault level
  output reg fault_o
);

  reg [`RFM_CNT_W-1:0] cnt_r;

  // counts runs of bad samples; saturates at the limit so fault stays sticky
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cnt_r <= {`RFM_CNT_W{1'b0}};
      fault_o <= 1'b0;
    end else if (sample_vld_i) begin
      if (!sample_bad_i) begin
        cnt_r <= {`RFM_CNT_W{1'b0}}; // see R14
      end else if (cnt_r < limit_i) begin
        cnt_r <= cnt_r + 1'b1;
        if (cnt_r + 1'b1 >= limit_i)
          fault_o <= 1'b1; // see R14
      end else begin
        fault_o <= 1'b1; // limit zero or already reached
      end
    end
  end

endmodule

`default_nettype wire

// ### src/rfm_top.v
/*
  range fault monitor: window checks on analog sense codes with
  consecutive-failure counting, power-up filter settle check and
  readback clamping.
  assumes sampled codes arrive with a valid strobe, all synchronous to mclk_i,
  and that the nonvolatile configuration word is stable after reset.
*/
// Behaviour
// R1: temperature circuit voltages outside window fault
// R2: common mode outside 30..80 percent faults
// R3: core bias current out of range faults
// R4: digital 5 V rail out of range faults
// R5: analog 5 V rail out of range faults
// R6: core rail outside 1.6..2.2 V faults
// R7: main supply outside 5.3..20 V faults
// R8: unsettled filters at power-up raise fault
// R9: settle fault sets unsettled flag
// R10: bridge-only unsettled clamps bridge readback only
// R11: temperature unsettled clamps both readbacks; here only an unsettled selected channel clamps, the other only faults
// R12: settle deadline from filter corner selection
// R13: failure limit from config bits 19..16
// R14: per-check counter, clears on good sample
`include "rfm_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module rfm_top #(
  // clock cycles per millisecond; a bench may scale it down to reach deadlines
  parameter CYC_PER_MS = `RFM_CLK_KHZ
) (
  // clock and reset
  input wire mclk_i,
  input wire sys_rst_i,
  // nonvolatile configuration word
  input wire [31:0] nv_cfg_i,
  // filter corner selects: 1 = 100 Hz, 0 = 40 Hz
  input wire brg_fast_i,
  input wire tmp_fast_i,
  // temperature channel select: 0 internal, 1 external
  input wire tmp_sel_ext_i,
  // sample strobe and codes
  input wire sample_vld_i,
  input wire [`RFM_CODE_W-1:0] tmp_int_v_i,
  input wire [`RFM_CODE_W-1:0] tmp_ext_v_i,
  input wire [`RFM_CODE_W-1:0] tmp_lo_i,
  input wire [`RFM_CODE_W-1:0] tmp_hi_i,
  input wire [`RFM_CODE_W-1:0] bridge_common_mode_i,
  input wire [`RFM_CODE_W-1:0] regulated_reference_i,
  input wire [`RFM_CODE_W-1:0] core_bias_current_i,
  input wire [`RFM_CODE_W-1:0] bias_lo_i,
  input wire [`RFM_CODE_W-1:0] bias_hi_i,
  input wire [`RFM_CODE_W-1:0] digital_5v_rail_i,
  input wire [`RFM_CODE_W-1:0] analog_5v_rail_i,
  input wire [`RFM_CODE_W-1:0] rail5_lo_i,
  input wire [`RFM_CODE_W-1:0] rail5_hi_i,
  input wire [`RFM_CODE_W-1:0] core_mv_i,
  input wire [`RFM_CODE_W+1:0] main_mv_i,
  // filter settle status
  input wire brg_settled_i,
  input wire tint_settled_i,
  input wire text_settled_i,
  // raw filter outputs for readback
  input wire [`RFM_RB_W-1:0] brg_data_i,
  input wire [`RFM_RB_W-1:0] tmp_data_i,
  // fault handler side
  output wire fault_o,
  output wire [`RFM_CHK_N-1:0] chk_fault_o,
  output reg filter_unsettled_flag_o,
  // readback values
  output reg [`RFM_RB_W-1:0] brg_rb_o,
  output reg [`RFM_RB_W-1:0] tmp_rb_o
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // true when code lies outside [lo, hi]
  function out_win;
    input [`RFM_CODE_W+1:0] v;
    input [`RFM_CODE_W+1:0] lo;
    input [`RFM_CODE_W+1:0] hi;
    begin
      out_win = (v < lo) || (v > hi);
    end
  endfunction

  // percent of a reference, 7-bit percent times 14-bit code over 100
  // no caller asks for more than the whole reference, so the quotient fits the
  // code width and its upper bits are dropped on purpose
  function [`RFM_CODE_W-1:0] pct_of;
    input [`RFM_CODE_W-1:0] ref_v;
    input [6:0] pct;
    reg [`RFM_CODE_W+6:0] prod;
    reg [`RFM_CODE_W+6:0] quot;
    begin
      prod = ref_v * pct;
      quot = prod / `RFM_PCT_FULL;
      pct_of = quot[`RFM_CODE_W-1:0];
    end
  endfunction

  // settle counts in clock cycles; products formed wide, then cut to the timer
  localparam [31:0] FAST_FULL = `RFM_SETTLE_FAST_MS * CYC_PER_MS;
  localparam [31:0] SLOW_FULL = `RFM_SETTLE_SLOW_MS * CYC_PER_MS;
  localparam [`RFM_TMR_W-1:0] FAST_CYC = FAST_FULL[`RFM_TMR_W-1:0];
  localparam [`RFM_TMR_W-1:0] SLOW_CYC = SLOW_FULL[`RFM_TMR_W-1:0];

  ////////////////////////////////////////////////////////////////////////
  // window checks

  wire [`RFM_CNT_W-1:0] limit_w;
  // the spare slot carries the settle fault, so only sampled checks get a bad bit
  wire [`RFM_CHK_SPARE-1:0] bad_w;
  wire [`RFM_CODE_W-1:0] vcm_lo_w;
  wire [`RFM_CODE_W-1:0] vcm_hi_w;

  assign limit_w = nv_cfg_i[`RFM_LIMIT_MSB:`RFM_LIMIT_LSB]; // see R13
  // integer floor of the percent, so a window edge that is exact stays in range
  assign vcm_lo_w = pct_of(regulated_reference_i, 7'd`RFM_VCM_LO_PCT);
  assign vcm_hi_w = pct_of(regulated_reference_i, 7'd`RFM_VCM_HI_PCT);

  // both temperature circuits watched, either out of window is a failure
  assign bad_w[`RFM_CHK_TEMP] =
    out_win({2'b00, tmp_int_v_i}, {2'b00, tmp_lo_i}, {2'b00, tmp_hi_i}) ||
    out_win({2'b00, tmp_ext_v_i}, {2'b00, tmp_lo_i}, {2'b00, tmp_hi_i}); // see R1
  assign bad_w[`RFM_CHK_VCM] = out_win({2'b00, bridge_common_mode_i},
    {2'b00, vcm_lo_w}, {2'b00, vcm_hi_w}); // see R2
  assign bad_w[`RFM_CHK_BIAS] = out_win({2'b00, core_bias_current_i},
    {2'b00, bias_lo_i}, {2'b00, bias_hi_i}); // see R3
  assign bad_w[`RFM_CHK_D5V] = out_win({2'b00, digital_5v_rail_i},
    {2'b00, rail5_lo_i}, {2'b00, rail5_hi_i}); // see R4
  assign bad_w[`RFM_CHK_A5V] = out_win({2'b00, analog_5v_rail_i},
    {2'b00, rail5_lo_i}, {2'b00, rail5_hi_i}); // see R5
  assign bad_w[`RFM_CHK_CORE] = out_win({2'b00, core_mv_i},
    16'd`RFM_CORE_LO_MV, 16'd`RFM_CORE_HI_MV); // see R6
  // tolerance lives in the attenuator, so hard limits are exact here
  assign bad_w[`RFM_CHK_MAIN] = out_win(main_mv_i,
    16'd`RFM_MAIN_LO_MV, 16'd`RFM_MAIN_HI_MV); // see R7

  // one counter per sampled check; all share the strobe and the one limit, so a
  // check that is in range never holds back the count of another

  // temperature circuits
  rfm_fail_counter u_cnt_temp (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .sample_vld_i(sample_vld_i),
    .sample_bad_i(bad_w[`RFM_CHK_TEMP]),
    .limit_i(limit_w),
    .fault_o(chk_fault_o[`RFM_CHK_TEMP])
  );

  // bridge common mode
  rfm_fail_counter u_cnt_vcm (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .sample_vld_i(sample_vld_i),
    .sample_bad_i(bad_w[`RFM_CHK_VCM]),
    .limit_i(limit_w),
    .fault_o(chk_fault_o[`RFM_CHK_VCM])
  );

  // core bias current
  rfm_fail_counter u_cnt_bias (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .sample_vld_i(sample_vld_i),
    .sample_bad_i(bad_w[`RFM_CHK_BIAS]),
    .limit_i(limit_w),
    .fault_o(chk_fault_o[`RFM_CHK_BIAS])
  );

  // digital 5 V rail
  rfm_fail_counter u_cnt_d5v (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .sample_vld_i(sample_vld_i),
    .sample_bad_i(bad_w[`RFM_CHK_D5V]),
    .limit_i(limit_w),
    .fault_o(chk_fault_o[`RFM_CHK_D5V])
  );

  // analog 5 V rail
  rfm_fail_counter u_cnt_a5v (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .sample_vld_i(sample_vld_i),
    .sample_bad_i(bad_w[`RFM_CHK_A5V]),
    .limit_i(limit_w),
    .fault_o(chk_fault_o[`RFM_CHK_A5V])
  );

  // core rail
  rfm_fail_counter u_cnt_core (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .sample_vld_i(sample_vld_i),
    .sample_bad_i(bad_w[`RFM_CHK_CORE]),
    .limit_i(limit_w),
    .fault_o(chk_fault_o[`RFM_CHK_CORE])
  );

  // main supply
  rfm_fail_counter u_cnt_main (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .sample_vld_i(sample_vld_i),
    .sample_bad_i(bad_w[`RFM_CHK_MAIN]),
    .limit_i(limit_w),
    .fault_o(chk_fault_o[`RFM_CHK_MAIN])
  );

  ////////////////////////////////////////////////////////////////////////
  // power-up settle check

  localparam [1:0] ST_WAIT = 2'b00;
  localparam [1:0] ST_DONE = 2'b01;

  reg [1:0] st_r;
  reg [`RFM_TMR_W-1:0] tmr_r;
  reg settle_fault_r;
  reg brg_unset_r;
  reg tmp_unset_r;
  wire [`RFM_TMR_W-1:0] brg_dl_w;
  wire [`RFM_TMR_W-1:0] tmp_dl_w;
  wire tmp_settled_w;
  wire [`RFM_TMR_W-1:0] tmr_nxt;
  wire brg_due_w;
  wire tmp_due_w;

  // bridge settles fast only when both filters are fast
  assign brg_dl_w = (brg_fast_i && tmp_fast_i) ? FAST_CYC : SLOW_CYC; // see R12
  assign tmp_dl_w = tmp_fast_i ? FAST_CYC : SLOW_CYC; // see R12
  assign tmp_settled_w = tmp_sel_ext_i ? text_settled_i : tint_settled_i;

  // deadlines compared against the next count, so each fires on exactly one edge
  assign tmr_nxt = tmr_r + 1'b1;
  assign brg_due_w = (tmr_nxt == brg_dl_w);
  assign tmp_due_w = (tmr_nxt == tmp_dl_w);

  // checks each filter at its own deadline, once, after reset
  // the timer stops at the slow deadline so it never wraps; a filter that
  // settles late cannot clear the fault, only a reset re-arms the check
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st_r <= ST_WAIT;
      tmr_r <= {`RFM_TMR_W{1'b0}};
      brg_unset_r <= 1'b0;
      tmp_unset_r <= 1'b0;
      settle_fault_r <= 1'b0;
      filter_unsettled_flag_o <= 1'b0;
    end else begin
      case (st_r)
        ST_WAIT: begin
          tmr_r <= tmr_nxt;
          if (brg_due_w && !brg_settled_i) begin
            brg_unset_r <= 1'b1; // see R8
            settle_fault_r <= 1'b1; // see R8
            filter_unsettled_flag_o <= 1'b1; // see R9
          end
          // either channel unsettled is a fault; only the selected one clamps
          if (tmp_due_w && !(tint_settled_i && text_settled_i)) begin
            settle_fault_r <= 1'b1; // see R8
            filter_unsettled_flag_o <= 1'b1; // see R9
            if (!tmp_settled_w)
              tmp_unset_r <= 1'b1;
          end
          if (tmr_nxt >= SLOW_CYC)
            st_r <= ST_DONE;
        end
        default: begin
          st_r <= ST_DONE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // readback clamp and fault output

  // clamp values registered so the readback never glitches
  // a clamp holds until reset; a filter settling later is not looked at again
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      brg_rb_o <= {`RFM_RB_W{1'b0}};
      tmp_rb_o <= {`RFM_RB_W{1'b0}};
    end else if (tmp_unset_r) begin
      brg_rb_o <= `RFM_CLAMP_VAL; // see R11
      tmp_rb_o <= `RFM_CLAMP_VAL; // see R11
    end else if (brg_unset_r) begin
      brg_rb_o <= `RFM_CLAMP_VAL; // see R10
      tmp_rb_o <= tmp_data_i; // see R10
    end else begin
      brg_rb_o <= brg_data_i;
      tmp_rb_o <= tmp_data_i;
    end
  end

  // settle fault rides in the spare slot so one reduction covers every cause
  assign chk_fault_o[`RFM_CHK_SPARE] = settle_fault_r;
  assign fault_o = |chk_fault_o;

endmodule

`default_nettype wire

// ### test/rfm_chk.sv
/* checker for the range fault monitor ports.
   assumes a bind onto rfm_top and a single clock domain. */
`include "rfm_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module rfm_chk (
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // inputs watched
  input wire logic [31:0] nv_cfg_i,
  input wire logic sample_vld_i,
  input wire logic [`RFM_CODE_W-1:0] core_mv_i,
  input wire logic [`RFM_CODE_W+1:0] main_mv_i,
  input wire logic [`RFM_RB_W-1:0] brg_data_i,
  // outputs watched
  input wire logic fault_o,
  input wire logic [`RFM_CHK_N-1:0] chk_fault_o,
  input wire logic filter_unsettled_flag_o,
  input wire logic [`RFM_RB_W-1:0] brg_rb_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // a limit of 0 or 1 faults on the first bad sample
  wire lim1 = nv_cfg_i[19:16] < 4'h2;
  wire core_bad = core_mv_i < `RFM_CORE_LO_MV || core_mv_i > `RFM_CORE_HI_MV;
  wire main_bad = main_mv_i < `RFM_MAIN_LO_MV || main_mv_i > `RFM_MAIN_HI_MV;
  ////////////////////////////////////////////////////////////////////////////
  chk_fault_sticky: assert property (!$past(sys_rst_i)
    |-> !(|($past(chk_fault_o) & ~chk_fault_o))) else $error("check fault bit cleared");
  chk_fault_or: assert property (fault_o == |chk_fault_o)
    else $error("fault line differs from check bits");
  chk_rise_sample: assert property (|(chk_fault_o[6:0] & ~$past(chk_fault_o[6:0]))
    |-> $past(sample_vld_i)) else $error("fault rose without sample");
  chk_core_first: assert property (sample_vld_i && lim1 && core_bad |=> chk_fault_o[5])
    else $error("core rail fault missed");
  chk_main_first: assert property (sample_vld_i && lim1 && main_bad |=> chk_fault_o[6])
    else $error("main supply fault missed");
  chk_core_good: assert property (sample_vld_i && !core_bad && !chk_fault_o[5]
    |=> !chk_fault_o[5]) else $error("core fault on good sample");
  chk_rb_follow: assert property (!$past(sys_rst_i) && !filter_unsettled_flag_o
    |-> brg_rb_o == $past(brg_data_i)) else $error("bridge readback altered");
  chk_flag_tied: assert property (filter_unsettled_flag_o == chk_fault_o[7])
    else $error("settle flag and fault differ");
  // main scenarios reached
  cover property (sample_vld_i && lim1 && core_bad ##1 chk_fault_o[5]);
  cover property ($rose(fault_o));
  cover property ($rose(filter_unsettled_flag_o));
  cover property (nv_cfg_i[19:16] == 4'h3 && $rose(fault_o));
endmodule
bind rfm_top rfm_chk chk_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .nv_cfg_i(nv_cfg_i),
  .sample_vld_i(sample_vld_i), .core_mv_i(core_mv_i), .main_mv_i(main_mv_i),
  .brg_data_i(brg_data_i), .fault_o(fault_o), .chk_fault_o(chk_fault_o),
  .filter_unsettled_flag_o(filter_unsettled_flag_o), .brg_rb_o(brg_rb_o));
`default_nettype wire

// ### test/rfm_hdl_model.sv
/* fault handler model: keeps the check pattern seen when the fault rose.
   assumes it shares the monitor clock and reset. */
`include "rfm_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module rfm_hdl_model (
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // fault lines
  input wire logic fault_o,
  input wire logic [`RFM_CHK_N-1:0] chk_fault_o,
  output logic [`RFM_CHK_N-1:0] cause_o
);
  // latch once; later faults do not overwrite the first cause
  always @(posedge mclk_i) begin
    if (sys_rst_i) cause_o <= 8'h00;
    else if (fault_o && cause_o == 8'h00) cause_o <= chk_fault_o;
  end
endmodule
`default_nettype wire

// ### test/rfm_top_tb.sv
/* testbench for the range fault monitor.
   assumes four cycles stand for a millisecond, so settle deadlines fall at 100 and 220. */
`include "rfm_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module rfm_top_tb;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [31:0] nv_cfg_i = 32'h0001_0000;
  logic sample_vld_i = 1'b0;
  logic [15:0] v [0:14] = '{500,500,100,1000,500,1000,500,100,1000,500,500,100,1000,1800,12000};
  logic [15:0] dflt [0:14] = '{500,500,100,1000,500,1000,500,100,1000,500,500,100,1000,1800,12000};
  logic [11:0] brg_d = 12'h0000;
  logic [11:0] tmp_d = 12'h0000;
  logic brg_fast = 1'b1;
  logic tmp_fast = 1'b1;
  logic sel_ext = 1'b0;
  logic [2:0] settled = 3'b000;
  logic fault_o, unset_o;
  logic [7:0] chk_o, cause;
  logic [11:0] brg_rb, tmp_rb;
  int n_fail = 0;
  int cmp_count = 0;
  int bi [0:7] = '{0,1,4,6,9,10,13,14};
  int bv [0:7] = '{50,50,200,2000,2000,50,2201,5299};
  int bb [0:7] = '{0,0,1,2,3,4,5,6};
  ////////////////////////////////////////////////////////////////////////////
  // settle levels start low; every sample scenario ends before the first deadline
  rfm_top #(.CYC_PER_MS(4)) dut_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .nv_cfg_i(nv_cfg_i),
    .brg_fast_i(brg_fast), .tmp_fast_i(tmp_fast), .tmp_sel_ext_i(sel_ext),
    .sample_vld_i(sample_vld_i),
    .tmp_int_v_i(v[0][13:0]), .tmp_ext_v_i(v[1][13:0]), .tmp_lo_i(v[2][13:0]),
    .tmp_hi_i(v[3][13:0]), .bridge_common_mode_i(v[4][13:0]),
    .regulated_reference_i(v[5][13:0]), .core_bias_current_i(v[6][13:0]),
    .bias_lo_i(v[7][13:0]), .bias_hi_i(v[8][13:0]), .digital_5v_rail_i(v[9][13:0]),
    .analog_5v_rail_i(v[10][13:0]), .rail5_lo_i(v[11][13:0]), .rail5_hi_i(v[12][13:0]),
    .core_mv_i(v[13][13:0]), .main_mv_i(v[14]), .brg_settled_i(settled[0]),
    .tint_settled_i(settled[1]), .text_settled_i(settled[2]), .brg_data_i(brg_d),
    .tmp_data_i(tmp_d),
    .fault_o(fault_o), .chk_fault_o(chk_o), .filter_unsettled_flag_o(unset_o),
    .brg_rb_o(brg_rb), .tmp_rb_o(tmp_rb));
  rfm_hdl_model hdl_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .fault_o(fault_o),
    .chk_fault_o(chk_o), .cause_o(cause));
  // clock
  always #20 mclk_i = ~mclk_i;
  ////////////////////////////////////////////////////////////////////////////
  // compare and count
  task chk(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task close_out;
    if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task rst(input int n);
    @(posedge mclk_i);
    sys_rst_i <= 1'b1;
    repeat (n) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
  endtask
  // n back-to-back samples with one code replaced
  task smp(input int n, input int k, input int val);
    @(posedge mclk_i);
    v[k] <= val[15:0];
    sample_vld_i <= 1'b1;
    repeat (n) @(posedge mclk_i);
    sample_vld_i <= 1'b0;
    v[k] <= dflt[k];
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // each check faults alone on its first bad sample at limit 1
  task t_each;
    for (int i = 0; i < 8; i++) begin
      rst(2);
      smp(1, bi[i], bv[i]);
      chk(chk_o, 12'h1 << bb[i]);
      @(posedge mclk_i);
      #1;
      chk(cause, 12'h1 << bb[i]);
    end
  endtask
  // window edges are in range
  task t_bounds;
    int bk [0:5] = '{13,13,14,14,4,4};
    int bw [0:5] = '{1600,2200,5300,20000,300,800};
    rst(2);
    for (int i = 0; i < 6; i++) smp(1, bk[i], bw[i]);
    chk(chk_o, 12'h000);
  endtask
  // limit 3: a good sample restarts the count
  task t_walk;
    nv_cfg_i <= 32'h0003_0000;
    rst(2);
    smp(2, 13, 1500);
    smp(1, 13, 1800);
    smp(2, 13, 1500);
    chk(chk_o, 12'h000);
    smp(1, 13, 1500);
    chk(chk_o, 12'h020);
  endtask
  // before the deadline readback is unclamped and flag low
  task t_rb;
    brg_d <= 12'h0123;
    tmp_d <= 12'h0456;
    repeat (2) @(posedge mclk_i);
    #1;
    chk(brg_rb, 12'h0123);
    chk(tmp_rb, 12'h0456);
    chk(unset_o, 12'h000);
  endtask
  // one power-up run: corners, channel and settle levels set before reset; the flag
  // is looked at one cycle before and at the deadline, the readback one cycle later
  task settle_run(input logic bf, input logic tf, input logic se, input logic [2:0] st,
                  input int dl, input logic [11:0] eb, input logic [11:0] et);
    brg_fast <= bf;
    tmp_fast <= tf;
    sel_ext <= se;
    settled <= st;
    rst(2);
    repeat (dl - 1) @(posedge mclk_i);
    #1;
    chk(unset_o, 12'h000);
    @(posedge mclk_i);
    #1;
    chk(unset_o, 12'h001);
    chk(chk_o, 12'h080);
    @(posedge mclk_i);
    #1;
    chk(brg_rb, eb);
    chk(tmp_rb, et);
    chk(cause, 12'h080);
  endtask
  // fast corners, bridge alone unsettled: bridge clamped at 25 ms, temperature passes
  task t_settle_brg;
    settle_run(1'b1, 1'b1, 1'b0, 3'b110, 100, `RFM_CLAMP_VAL, 12'h0456);
  endtask
  // slow temperature corner, selected external channel unsettled: both clamped at 55 ms
  task t_settle_sel;
    settle_run(1'b1, 1'b0, 1'b1, 3'b011, 220, `RFM_CLAMP_VAL, `RFM_CLAMP_VAL);
  endtask
  // slow bridge, fast temperature, unselected channel unsettled: fault at 25 ms, no clamp
  task t_settle_other;
    settle_run(1'b0, 1'b1, 1'b0, 3'b011, 100, 12'h0123, 12'h0456);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst(20);
    #1;
    chk(fault_o, 12'h000);
    t_each;
    t_bounds;
    t_walk;
    t_rb;
    t_settle_brg;
    t_settle_sel;
    t_settle_other;
    close_out;
  end
  // watchdog, well above the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge mclk_i);
    n_fail++;
    close_out;
  end
endmodule
`default_nettype wire
